// ==== dfip_top.sv ====
// Filtered 32-channel input port with edge interrupts and an APB slave.
// Assumes pins are synchronous to clock and a pull-up holds idle pins high.
`timescale 1ns/10ps
module dfip_top
  import dfip_pkg::*;
#(
  parameter int unsigned CH = 32
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic [CH-1:0] pin_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  output logic               irq
);

  generate
    if (CH < 1 || CH > 32) begin : g_chk
      $error("dfip_top: CH must be 1 to 32");
    end
  endgenerate

  // Software-visible state
  logic [CH-1:0] irq_en;
  logic [CH-1:0] edge_sel;
  logic [CH-1:0] status;
  logic [31:0]   filt_cfg;
  logic [CH-1:0] next_irq_en;
  logic [CH-1:0] next_edge_sel;
  logic [CH-1:0] next_status;
  logic [31:0]   next_filt_cfg;

  // Data path state
  logic [CH-1:0] raw;
  logic [CH-1:0] data;
  logic [CH-1:0] data_d;
  logic [CH-1:0] rise;
  logic [CH-1:0] fall;
  logic [CH-1:0] hit;
  logic          tick;
  logic          next_irq;

  // Bus state
  dfip_apb_t     apb_st;
  dfip_apb_t     next_apb_st;
  logic [31:0]   next_prdata;
  logic          next_pready;
  logic          next_pslverr;
  logic          wr_go;
  logic [CH-1:0] clr_mask;

  // Widen a channel vector into a bus word, upper bits read zero
  function automatic logic [31:0] widen(input logic [CH-1:0] v);
    logic [31:0] w;
    w = '0;
    w[CH-1:0] = v;
    return w;
  endfunction : widen

  // True when the address names one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_DATA) || (a == OFF_IRQ_EN) || (a == OFF_EDGE) ||
           (a == OFF_STATUS) || (a == OFF_FILT) || (a == OFF_RAW);
  endfunction : mapped

  // Pins are active low, so the channel bit is the inverted level
  assign raw = ~pin_n; // [R2] [R3]

  // Sample rate for the filter; slower ticks reject longer chatter
  dfip_tick #(
    .W      (FILT_DIV_W)
  ) u_tick (
    .clock  (clock),
    .nrst   (nrst),
    .period (filt_cfg[FILT_DIV_LSB +: FILT_DIV_W]),
    .tick   (tick)
  );

  // One filter per channel, all sharing the software settings
  dfip_filter #(
    .CH     (CH),
    .CW     (FILT_CNT_W)
  ) u_filter (
    .clock  (clock),
    .nrst   (nrst),
    .enable (filt_cfg[FILT_EN_BIT]), // [R8]
    .tick   (tick),
    .need   (filt_cfg[FILT_CNT_LSB +: FILT_CNT_W]),
    .din    (raw),
    .dout   (data)
  );

  // Edge detect on the filtered data, one cycle behind it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      data_d <= '0;
    end else begin
      data_d <= data;
    end
  end

  // A data rise is the pin falling, a data fall is the pin rising
  assign rise = data & ~data_d;  // [R6]
  assign fall = ~data & data_d;  // [R6]

  // Each channel picks its own edge and is gated by its own enable
  assign hit = irq_en &
               ((edge_sel & rise) | (~edge_sel & fall)); // [R1] [R4] [R5]

  // Write strobe only at the edge that completes the access phase
  assign wr_go = psel & penable & pready & pwrite & ~pslverr;

  assign clr_mask = (wr_go && paddr == OFF_STATUS) ? pwdata[CH-1:0] : '0;

  // Configuration writes
  always_comb begin
    next_irq_en   = irq_en;
    next_edge_sel = edge_sel;
    next_filt_cfg = filt_cfg;
    if (wr_go) begin
      case (paddr)
        OFF_IRQ_EN: begin
          next_irq_en = pwdata[CH-1:0]; // [R4]
        end
        OFF_EDGE: begin
          next_edge_sel = pwdata[CH-1:0]; // [R5]
        end
        OFF_FILT: begin
          next_filt_cfg = pwdata; // [R8]
        end
        default: begin
          next_irq_en = irq_en;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_en   <= RST_IRQ_EN[CH-1:0];
      edge_sel <= RST_EDGE[CH-1:0];
      filt_cfg <= RST_FILT;
    end else begin
      irq_en   <= next_irq_en;
      edge_sel <= next_edge_sel;
      filt_cfg <= next_filt_cfg;
    end
  end

  // Pending flags: a new edge wins over a clear in the same cycle
  always_comb begin
    next_status = (status & ~clr_mask) | hit; // [R9]
    next_irq    = |(next_status & next_irq_en); // [R7] [R9]
  end

  // Interrupt is registered so the pin never glitches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status <= RST_STATUS[CH-1:0];
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= next_irq; // [R7]
    end
  end

  // APB answer: setup cycle loads read data, access phase sees pready
  always_comb begin
    next_apb_st  = apb_st;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (apb_st)
      DFIP_IDLE: begin
        if (psel && !penable) begin
          next_apb_st  = DFIP_ANSWER;
          next_pready  = 1'b1;
          next_pslverr = ~mapped(paddr);
          next_prdata  = '0;
          if (!pwrite) begin
            case (paddr)
              OFF_DATA:   next_prdata = widen(data); // [R1] [R3]
              OFF_IRQ_EN: next_prdata = widen(irq_en);
              OFF_EDGE:   next_prdata = widen(edge_sel);
              OFF_STATUS: next_prdata = widen(status);
              OFF_FILT:   next_prdata = filt_cfg;
              OFF_RAW:    next_prdata = widen(raw);
              default:    next_prdata = '0;
            endcase
          end
        end
      end
      DFIP_ANSWER: begin
        // Answer lasts one cycle; the master drops penable next
        next_apb_st = DFIP_IDLE;
      end
      default: begin
        next_apb_st = DFIP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      apb_st  <= DFIP_IDLE;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      apb_st  <= next_apb_st;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : dfip_top

// ==== dfip_pkg.sv ====
// Constants shared by the filtered input port: register map, fields, resets.
// Assumes a single 25 MHz clock and an APB register bus with 32-bit data.
// Notes on behaviour
// [R1] Thirty-two independent input channels, each one usable as an interrupt.
// [R2] Every pin is active low; its level is inverted into the data bit.
// [R3] High pin reads as data 0, low pin reads as data 1.
// [R4] Software enables or disables interrupt generation per input bit.
// [R5] Software selects rising or falling data edge per input bit.
// [R6] Rising data edge is pin high-to-low; falling is pin low-to-high.
// [R7] All channel requests merge onto one shared level interrupt output.
// [R8] Each input passes a software-configurable digital noise filter.
// [R9] Enabled selected edge latches a pending flag until software clears it.
package dfip_pkg;

  // Clock rate, for reference when programming the filter divider
  localparam int unsigned CLK_HZ = 25_000_000;

  // Register byte offsets
  localparam logic [7:0] OFF_DATA   = 8'h00; // filtered data, read only
  localparam logic [7:0] OFF_IRQ_EN = 8'h04; // per-bit interrupt enable
  localparam logic [7:0] OFF_EDGE   = 8'h08; // 1 rising, 0 falling
  localparam logic [7:0] OFF_STATUS = 8'h0c; // pending, write one to clear
  localparam logic [7:0] OFF_FILT   = 8'h10; // filter control
  localparam logic [7:0] OFF_RAW    = 8'h14; // unfiltered data, read only

  // Filter control fields
  localparam int unsigned FILT_DIV_LSB = 0;
  localparam int unsigned FILT_DIV_W   = 16;
  localparam int unsigned FILT_CNT_LSB = 16;
  localparam int unsigned FILT_CNT_W   = 4;
  localparam int unsigned FILT_EN_BIT  = 31;

  // Reset values
  localparam logic [31:0] RST_IRQ_EN = 32'h0000_0000;
  localparam logic [31:0] RST_EDGE   = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] RST_FILT   = 32'h0001_0000; // off, div 0, count 1

  // APB answer states
  typedef enum logic [1:0] {
    DFIP_IDLE,
    DFIP_ANSWER
  } dfip_apb_t;

endpackage : dfip_pkg

// ==== dfip_tick.sv ====
// Divider giving a one-cycle sample enable for the input filter.
// Assumes period is stable or that a glitch on change is harmless.
`timescale 1ns/10ps
module dfip_tick
  import dfip_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] period,
  output logic              tick
);

  generate
    if (W < 1 || W > 31) begin : g_chk
      $error("dfip_tick: W out of range");
    end
  endgenerate

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_tick;

  // Pulse once every period+1 cycles; period zero pulses every cycle
  always_comb begin
    if (cnt >= period) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt  = cnt + W'(1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : dfip_tick

// ==== dfip_filter.sv ====
// Per-channel chatter filter: a level is accepted only after it has been
// sampled unchanged on a number of consecutive ticks.
// Assumes inputs already synchronous to clock; bypass passes them through.
`timescale 1ns/10ps
module dfip_filter
  import dfip_pkg::*;
#(
  parameter int unsigned CH = 32,
  parameter int unsigned CW = 4
) (
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          enable,
  input  wire logic          tick,
  input  wire logic [CW-1:0] need,
  input  wire logic [CH-1:0] din,
  output logic      [CH-1:0] dout
);

  generate
    if (CH < 1 || CH > 32 || CW < 1 || CW > 8) begin : g_chk
      $error("dfip_filter: parameters out of range");
    end
  endgenerate

  logic [CW-1:0] cnt      [CH];
  logic [CW-1:0] next_cnt [CH];
  logic [CH-1:0] next_dout;

  // Count agreeing samples; any return to the held level restarts the count
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      next_cnt[i]  = cnt[i];
      next_dout[i] = dout[i];
      if (!enable) begin
        next_cnt[i]  = '0;
        next_dout[i] = din[i];
      end else if (tick) begin
        if (din[i] == dout[i]) begin
          next_cnt[i] = '0;
        end else if (cnt[i] + CW'(1) >= need) begin // [R8]
          next_cnt[i]  = '0;
          next_dout[i] = din[i];
        end else begin
          next_cnt[i] = cnt[i] + CW'(1);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dout <= '0;
      for (int i = 0; i < CH; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      dout <= next_dout;
      for (int i = 0; i < CH; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

endmodule : dfip_filter

// ==== dfip_checker.sv ====
// Port checks of dfip_top: APB timing, errors, raw data, irq release.
// Assumes it is bound to dfip_top and sees its ports only.
`timescale 1ns/10ps
module dfip_checker
  import dfip_pkg::*;
#(
  parameter int unsigned CH = 32
) (
  input wire logic          clock,
  input wire logic          nrst,
  input wire logic [CH-1:0] pin_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [CH-1:0] pin_d;
  logic [1:0]    quiet, next_quiet;
  logic          wr_hit;

  // Cycles the pins held still, saturating so it never wraps
  always_comb begin
    next_quiet = (pin_n != pin_d) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_d <= '0;
      quiet <= 2'h0;
    end else begin
      pin_d <= pin_n;
      quiet <= next_quiet;
    end
  end
  assign wr_hit = psel && penable && pwrite && pready;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence

  a_zero_wait: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_one_pulse: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_ready_access: assert property (pready |-> s_answer)
    else $error("answer outside access");
  a_bad_addr: assert property (pready && paddr > OFF_RAW |-> pslverr)
    else $error("unmapped access not refused");
  a_good_addr: assert property
    (pready && paddr <= OFF_RAW && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_raw_invert: assert property
    (pready && !pwrite && paddr == OFF_RAW && quiet == 2'h3
     && $stable(pin_n) |-> prdata[CH-1:0] == ~pin_n)
    else $error("raw data not inverted pins");
  a_irq_release: assert property ($fell(irq) |-> $past(wr_hit))
    else $error("irq dropped without a write");
endmodule : dfip_checker

bind dfip_top dfip_checker #(.CH(CH)) u_chk (
  .clock(clock), .nrst(nrst), .pin_n(pin_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
);

// ==== dfip_switches.sv ====
// Switch or TTL source model driving the 32 input pins.
// Assumes pull-ups: an open contact leaves its pin high.
`timescale 1ns/10ps
module dfip_switches (
  input  wire logic        clock,
  input  wire logic [31:0] closed,
  input  wire logic        chatter,
  output logic      [31:0] pin_n
);
  // Closed contacts pull low; chatter toggles them every cycle
  initial pin_n = 32'hffff_ffff;
  always @(posedge clock) begin
    pin_n <= chatter ? (pin_n ^ closed) : ~closed;
  end
endmodule : dfip_switches

// ==== filtered_input_port_irq_tb_top.sv ====
// Self-checking bench for the filtered input port and its irq line.
// Assumes dfip_pkg, dfip_top, checker and switch model compiled first.
`timescale 1ns/10ps
module filtered_input_port_irq_tb_top;
  import dfip_pkg::*;
  logic        clock = 1'b0, nrst = 1'b0, chatter = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, closed = 32'h0;
  logic [31:0] pin_n, prdata, v, e, m, old, st;
  logic        pready, pslverr, irq;
  logic [32:0] expq[$];
  int          fails = 0, checks = 0, cyc = 0;
  integer      seed = 32'hac14a57a;

  // Clock at 25 MHz
  initial begin
    forever #20 clock = ~clock;
  end

  dfip_switches sw (.clock(clock), .closed(closed), .chatter(chatter),
    .pin_n(pin_n));
  dfip_top dut (.clock(clock), .nrst(nrst), .pin_n(pin_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  // Request held until pready; reads queue their expected answer
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic err = 1'b0);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back({err, d});
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
  endtask : apb

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge clock);
  endtask : idle

  // Read answers are matched against the oldest note
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0) begin
        fails++;
        $display("unexpected at %0t: got %h want %h", $time,
                 {pslverr, prdata}, 33'h0);
      end else cmp({pslverr, prdata}, expq.pop_front());
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, cyc, 32'h0);
      finish_test();
    end
  end

  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(0, OFF_IRQ_EN, RST_IRQ_EN);
    apb(0, OFF_EDGE, RST_EDGE);
    apb(0, OFF_STATUS, RST_STATUS);
    apb(0, OFF_FILT, RST_FILT);
    apb(0, 8'h18, 32'h0, 1'b1);
    apb(1, 8'hfc, 32'h5a5a_5a5a, 1'b1);
    // Low pins read as ones, high pins as zeros, data writes ignored
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      closed <= v;
      idle(5);
      apb(1, OFF_DATA, ~v);
      apb(0, OFF_DATA, v);
      apb(0, OFF_RAW, v);
    end
    old = v;
    // Random edge select and enables; mask, then clear pending
    for (int i = 0; i < 6; i++) begin
      e = $random(seed);
      m = $random(seed);
      v = $random(seed);
      apb(1, OFF_STATUS, 32'hffff_ffff);
      apb(1, OFF_EDGE, e);
      apb(1, OFF_IRQ_EN, m);
      closed <= v;
      idle(6);
      st = ((v & ~old & e) | (~v & old & ~e)) & m;
      cmp({32'h0, irq}, {32'h0, st != 32'h0});
      apb(0, OFF_STATUS, st);
      apb(1, OFF_IRQ_EN, 32'h0);
      idle(2);
      cmp({32'h0, irq}, 33'h0);
      apb(0, OFF_STATUS, st);
      apb(1, OFF_STATUS, 32'hffff_ffff);
      apb(0, OFF_STATUS, 32'h0);
      old = v;
    end
    // Chatter must not pass the filter; a steady level must
    apb(1, OFF_FILT, 32'h8003_0002);
    apb(0, OFF_FILT, 32'h8003_0002);
    v = $random(seed);
    chatter <= 1'b1;
    closed <= v;
    idle(30);
    apb(0, OFF_DATA, old);
    chatter <= 1'b0;
    idle(30);
    apb(0, OFF_DATA, v);
    idle(2);
    if (expq.size() != 0) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, expq.size(),
               32'h0);
    end
    finish_test();
  end
endmodule : filtered_input_port_irq_tb_top
